// ### hw/fwsr_pkg.sv
// Constants shared by the flash status-polling controller
`default_nettype none
package fwsr_pkg;
  localparam int unsigned CLK_NS  = 25;
  localparam int unsigned T_RC_NS = 70;
  localparam int unsigned T_WP_NS = 35;
  localparam int unsigned RD_CYC  = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;

  localparam int unsigned AW = 17;
  localparam int unsigned DW = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_WDATA    = 8'h08;
  localparam logic [7:0] REG_RDATA    = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h18;
  localparam logic [7:0] REG_IRQ_EN   = 8'h1C;

  // Opcodes written to the command register, and its abort bit number
  localparam logic [2:0] OP_READ      = 3'h1;
  localparam logic [2:0] OP_WRITE     = 3'h2;
  localparam logic [2:0] OP_POLL      = 3'h3;
  localparam logic [2:0] OP_RESET     = 3'h4;
  localparam logic [2:0] OP_ERASE_ADD = 3'h5;
  localparam int unsigned CMD_ABORT   = 3;

  // Flash data byte fields and command bytes
  localparam int unsigned DATA_COMPLEMENT_POLL_BIT = 7;
  localparam int unsigned TOGGLE_STATUS_BIT        = 6;
  localparam int unsigned TIMING_LIMIT_FAIL_BIT    = 5;
  localparam int unsigned ERASE_WINDOW_TIMER_BIT   = 3;
  localparam logic [7:0] FL_RESET_CMD   = 8'hF0;
  localparam logic [7:0] FL_SECTOR_CONF = 8'h30;

  // Status register bits
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_OK      = 1;
  localparam int unsigned ST_FAIL    = 2;
  localparam int unsigned ST_DROPPED = 3;
  localparam int unsigned ST_ABORTED = 4;

  // Interrupt event bits
  localparam int unsigned NEV    = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_FAIL = 1;
  localparam int unsigned EV_DROP = 2;

  typedef enum logic [3:0] {
    FWSR_IDLE   = 4'h0,
    FWSR_RDA    = 4'h1,
    FWSR_RDB    = 4'h2,
    FWSR_RDC    = 4'h3,
    FWSR_RDD    = 4'h4,
    FWSR_ARRAY  = 4'h5,
    FWSR_RSTW   = 4'h6,
    FWSR_EPRE   = 4'h7,
    FWSR_EWR    = 4'h8,
    FWSR_EPOST  = 4'h9,
    FWSR_SINGLE = 4'hA
  } fwsr_state_t;

  typedef enum logic [1:0] {
    FWSR_PH_IDLE   = 2'h0,
    FWSR_PH_SETUP  = 2'h1,
    FWSR_PH_STROBE = 2'h2,
    FWSR_PH_HOLD   = 2'h3
  } fwsr_phase_t;
endpackage
`default_nettype wire

// ### hw/fwsr_cycle.sv
// One asynchronous flash bus cycle, read or write
`default_nettype none
module fwsr_cycle (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   start_i,
  input  wire logic                   we_i,
  input  wire logic [fwsr_pkg::AW-1:0] addr_i,
  input  wire logic [fwsr_pkg::DW-1:0] dat_i,
  output logic                        done_o,
  output logic [fwsr_pkg::DW-1:0]     rdat_o,
  output logic                        fl_ce_n_o,
  output logic                        fl_oe_n_o,
  output logic                        fl_we_n_o,
  output logic [fwsr_pkg::AW-1:0]     fl_addr_o,
  output logic [fwsr_pkg::DW-1:0]     fl_dq_o,
  output logic                        fl_dq_oe_n_o,
  input  wire logic [fwsr_pkg::DW-1:0] fl_dq_i
);
  fwsr_pkg::fwsr_phase_t phase;
  logic [3:0]            cnt;
  logic                  wr;

  ////////////////////////////////////////////////////////////////////////
  // Setup one cycle, strobe for the access time, then one idle cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= fwsr_pkg::FWSR_PH_IDLE;
      cnt   <= 4'h0;
      wr    <= 1'b0;
    end else begin
      unique case (phase)
        fwsr_pkg::FWSR_PH_IDLE: begin
          if (start_i) begin
            phase <= fwsr_pkg::FWSR_PH_SETUP;
            wr    <= we_i;
          end
        end
        fwsr_pkg::FWSR_PH_SETUP: begin
          phase <= fwsr_pkg::FWSR_PH_STROBE;
          cnt   <= wr ? 4'(fwsr_pkg::WP_CYC - 1) : 4'(fwsr_pkg::RD_CYC - 1);
        end
        fwsr_pkg::FWSR_PH_STROBE: begin
          if (cnt == 4'h0) begin
            phase <= fwsr_pkg::FWSR_PH_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        fwsr_pkg::FWSR_PH_HOLD: begin
          phase <= fwsr_pkg::FWSR_PH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive; strobes go high in the hold cycle so every read is distinct
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_ce_n_o    <= 1'b1;
      fl_oe_n_o    <= 1'b1;
      fl_we_n_o    <= 1'b1;
      fl_addr_o    <= '0;
      fl_dq_o      <= 8'h00;
      fl_dq_oe_n_o <= 1'b1;
    end else if (phase == fwsr_pkg::FWSR_PH_IDLE && start_i) begin
      fl_ce_n_o    <= 1'b0;
      fl_addr_o    <= addr_i;
      fl_dq_o      <= dat_i;
      fl_dq_oe_n_o <= !we_i;
    end else if (phase == fwsr_pkg::FWSR_PH_SETUP) begin
      fl_oe_n_o <= wr;
      fl_we_n_o <= !wr;
    end else if (phase == fwsr_pkg::FWSR_PH_STROBE && cnt == 4'h0) begin
      fl_ce_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
    end else if (phase == fwsr_pkg::FWSR_PH_HOLD) begin
      fl_dq_oe_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (phase == fwsr_pkg::FWSR_PH_STROBE && cnt == 4'h0);
      if (phase == fwsr_pkg::FWSR_PH_STROBE && cnt == 4'h0 && !wr) begin
        rdat_o <= fl_dq_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/fwsr_irq.sv
// Sticky event status, enable mask and level interrupt
`default_nettype none
module fwsr_irq (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [fwsr_pkg::NEV-1:0] ev_i,
  input  wire logic [fwsr_pkg::NEV-1:0] clr_i,
  input  wire logic                     en_we_i,
  input  wire logic [fwsr_pkg::NEV-1:0] en_i,
  output logic      [fwsr_pkg::NEV-1:0] stat_o,
  output logic      [fwsr_pkg::NEV-1:0] en_o,
  output logic                          irq_o
);
  // An event in the clear cycle survives the clear
  genvar g;
  for (g = 0; g < fwsr_pkg::NEV; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stat_o[g] <= 1'b0;
      end else if (ev_i[g]) begin
        stat_o[g] <= 1'b1;
      end else if (clr_i[g]) begin
        stat_o[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_o <= '0;
    end else if (en_we_i) begin
      en_o <= en_i;
    end
  end

  assign irq_o = |(stat_o & en_o);
endmodule
`default_nettype wire

// ### hw/fwsr_host.sv
// Host controller that drives the flash and runs its status procedures
//
// Functional notes
// - Begin toggle checking with two back-to-back full-byte reads, compare toggle bit.
// - Still toggling: look at fail bit; if high, check toggling once more.
// - Fail bit high and still toggling: failed, host writes reset command.
// - Host leaving polling restarts the procedure from the first double read.
// - After any indicated failure the host issues the reset command.
// - Host may skip timer check only if added commands come within 50 us.
// - Check timer bit before and after each added sector command.
// - Host reads poll bit at the program address or an erasing sector.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`default_nettype none
module fwsr_host (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output logic                         irq_o,
  output logic                         fl_ce_n_o,
  output logic                         fl_oe_n_o,
  output logic                         fl_we_n_o,
  output logic      [fwsr_pkg::AW-1:0] fl_addr_o,
  output logic      [fwsr_pkg::DW-1:0] fl_dq_o,
  output logic                         fl_dq_oe_n_o,
  input  wire logic [fwsr_pkg::DW-1:0] fl_dq_i
);
  fwsr_pkg::fwsr_state_t     state;
  logic [fwsr_pkg::AW-1:0]   addr;
  logic [fwsr_pkg::DW-1:0]   wdata;
  logic [fwsr_pkg::DW-1:0]   rdata;
  logic [2:0]                op;
  logic                      abort_req;
  logic                      st_ok;
  logic                      st_fail;
  logic                      st_dropped;
  logic                      st_aborted;
  logic                      first_toggle;
  logic                      pend;
  logic                      cyc_start;
  logic                      cyc_we;
  logic [fwsr_pkg::AW-1:0]   cyc_addr;
  logic [fwsr_pkg::DW-1:0]   cyc_wdat;
  logic                      cyc_done;
  logic [fwsr_pkg::DW-1:0]   cyc_rdat;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      byte0_wr;
  logic                      cmd_go;
  logic [fwsr_pkg::NEV-1:0]  ev;
  logic [fwsr_pkg::NEV-1:0]  irq_stat;
  logic [fwsr_pkg::NEV-1:0]  irq_en;
  logic                      busy;
  logic                      toggled;
  logic                      fail_seen;
  logic                      timer_seen;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: ack one cycle after the request, then drops
  assign bus_req  = cyc_i && stb_i && !ack_o;
  assign bus_wr   = bus_req && we_i;
  assign byte0_wr = bus_wr && sel_i[0];
  assign busy     = (state != fwsr_pkg::FWSR_IDLE);
  assign cmd_go   = byte0_wr && adr_i == fwsr_pkg::REG_CMD && !busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      unique case (adr_i)
        fwsr_pkg::REG_CMD:      dat_o <= {29'h0, op};
        fwsr_pkg::REG_ADDR:     dat_o <= {15'h0, addr};
        fwsr_pkg::REG_WDATA:    dat_o <= {24'h0, wdata};
        fwsr_pkg::REG_RDATA:    dat_o <= {24'h0, rdata};
        fwsr_pkg::REG_STATUS:   dat_o <= {27'h0, st_aborted, st_dropped, st_fail, st_ok, busy};
        fwsr_pkg::REG_IRQ_STAT: dat_o <= {29'h0, irq_stat};
        fwsr_pkg::REG_IRQ_EN:   dat_o <= {29'h0, irq_en};
        default:                dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Address and data are locked while an operation runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr  <= '0;
      wdata <= 8'h00;
    end else if (bus_wr && !busy) begin
      if (adr_i == fwsr_pkg::REG_ADDR) begin
        if (sel_i[0]) addr[7:0] <= dat_i[7:0];
        if (sel_i[1]) addr[15:8] <= dat_i[15:8];
        if (sel_i[2]) addr[16] <= dat_i[16];
      end
      if (adr_i == fwsr_pkg::REG_WDATA && sel_i[0]) begin
        wdata <= dat_i[7:0];
      end
    end
  end

  // Abort lets the host walk away; a new poll starts from scratch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_req <= 1'b0;
    end else if (state == fwsr_pkg::FWSR_IDLE) begin
      abort_req <= 1'b0;
    end else if (byte0_wr && adr_i == fwsr_pkg::REG_CMD && dat_i[fwsr_pkg::CMD_ABORT]) begin
      abort_req <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash cycle requests from the sequencer
  always_comb begin
    cyc_start = 1'b0;
    cyc_we    = 1'b0;
    cyc_addr  = addr;
    cyc_wdat  = wdata;
    unique case (state)
      fwsr_pkg::FWSR_IDLE: begin
      end
      fwsr_pkg::FWSR_RSTW: begin
        cyc_start = !pend;
        cyc_we    = 1'b1;
        cyc_wdat  = fwsr_pkg::FL_RESET_CMD;
      end
      fwsr_pkg::FWSR_EWR: begin
        cyc_start = !pend;
        cyc_we    = 1'b1;
        cyc_wdat  = fwsr_pkg::FL_SECTOR_CONF;
      end
      fwsr_pkg::FWSR_SINGLE: begin
        cyc_start = !pend;
        cyc_we    = (op == fwsr_pkg::OP_WRITE);
      end
      default: begin
        // Status reads use the operation's own address
        cyc_start = !pend;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 1'b0;
    end else if (cyc_done) begin
      pend <= 1'b0;
    end else if (cyc_start) begin
      pend <= 1'b1;
    end
  end

  assign toggled    = cyc_rdat[fwsr_pkg::TOGGLE_STATUS_BIT] != first_toggle;
  assign fail_seen  = cyc_rdat[fwsr_pkg::TIMING_LIMIT_FAIL_BIT];
  assign timer_seen = cyc_rdat[fwsr_pkg::ERASE_WINDOW_TIMER_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= fwsr_pkg::FWSR_IDLE;
      op    <= 3'h0;
    end else if (state == fwsr_pkg::FWSR_IDLE) begin
      if (cmd_go) begin
        op <= dat_i[2:0];
        unique case (dat_i[2:0])
          fwsr_pkg::OP_READ:      state <= fwsr_pkg::FWSR_SINGLE;
          fwsr_pkg::OP_WRITE:     state <= fwsr_pkg::FWSR_SINGLE;
          fwsr_pkg::OP_POLL:      state <= fwsr_pkg::FWSR_RDA;
          fwsr_pkg::OP_RESET:     state <= fwsr_pkg::FWSR_RSTW;
          fwsr_pkg::OP_ERASE_ADD: state <= fwsr_pkg::FWSR_EPRE;
          default:                state <= fwsr_pkg::FWSR_IDLE;
        endcase
      end
    end else if (cyc_done) begin
      unique case (state)
        fwsr_pkg::FWSR_RDA: state <= fwsr_pkg::FWSR_RDB;
        fwsr_pkg::FWSR_RDB: begin
          if (!toggled) begin
            state <= fwsr_pkg::FWSR_ARRAY;
          end else if (fail_seen) begin
            state <= fwsr_pkg::FWSR_RDC;
          end else if (abort_req) begin
            state <= fwsr_pkg::FWSR_IDLE;
          end else begin
            state <= fwsr_pkg::FWSR_RDA;
          end
        end
        fwsr_pkg::FWSR_RDC: state <= fwsr_pkg::FWSR_RDD;
        fwsr_pkg::FWSR_RDD: begin
          if (!toggled) begin
            state <= fwsr_pkg::FWSR_ARRAY;
          end else begin
            state <= fwsr_pkg::FWSR_RSTW;
          end
        end
        fwsr_pkg::FWSR_EPRE: begin
          // Timer bit read before every add, never skipped; set means no more sectors
          state <= timer_seen ? fwsr_pkg::FWSR_IDLE : fwsr_pkg::FWSR_EWR;
        end
        fwsr_pkg::FWSR_EWR: state <= fwsr_pkg::FWSR_EPOST;
        default: state <= fwsr_pkg::FWSR_IDLE;
      endcase
    end
  end

  // Toggle bit of the first read of each pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_toggle <= 1'b0;
    end else if (cyc_done && (state == fwsr_pkg::FWSR_RDA || state == fwsr_pkg::FWSR_RDC)) begin
      first_toggle <= cyc_rdat[fwsr_pkg::TOGGLE_STATUS_BIT];
    end
  end

  // Read data: last status byte, or array data after completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else if (cyc_done && !cyc_we) begin
      rdata <= cyc_rdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result flags, cleared when a new operation starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ok      <= 1'b0;
      st_fail    <= 1'b0;
      st_dropped <= 1'b0;
      st_aborted <= 1'b0;
    end else if (cmd_go) begin
      st_ok      <= 1'b0;
      st_fail    <= 1'b0;
      st_dropped <= 1'b0;
      st_aborted <= 1'b0;
    end else if (cyc_done) begin
      unique case (state)
        fwsr_pkg::FWSR_ARRAY: st_ok <= 1'b1;
        fwsr_pkg::FWSR_SINGLE: st_ok <= 1'b1;
        fwsr_pkg::FWSR_RDB: st_aborted <= toggled && !fail_seen && abort_req;
        fwsr_pkg::FWSR_RDD: st_fail <= toggled;
        fwsr_pkg::FWSR_RSTW: st_ok <= (op == fwsr_pkg::OP_RESET);
        fwsr_pkg::FWSR_EPRE: st_dropped <= timer_seen;
        // Timer high after the add: the command may have been lost
        fwsr_pkg::FWSR_EPOST: begin
          st_dropped <= timer_seen;
          st_ok      <= !timer_seen;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    ev = '0;
    if (cyc_done) begin
      ev[fwsr_pkg::EV_DONE] = (state == fwsr_pkg::FWSR_ARRAY) || (state == fwsr_pkg::FWSR_SINGLE)
                           || (state == fwsr_pkg::FWSR_EPOST && !timer_seen)
                           || (state == fwsr_pkg::FWSR_RSTW && op == fwsr_pkg::OP_RESET);
      ev[fwsr_pkg::EV_FAIL] = (state == fwsr_pkg::FWSR_RSTW && op == fwsr_pkg::OP_POLL);
      ev[fwsr_pkg::EV_DROP] = (state == fwsr_pkg::FWSR_EPRE || state == fwsr_pkg::FWSR_EPOST) && timer_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules
  fwsr_cycle u_cycle (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .start_i      (cyc_start),
    .we_i         (cyc_we),
    .addr_i       (cyc_addr),
    .dat_i        (cyc_wdat),
    .done_o       (cyc_done),
    .rdat_o       (cyc_rdat),
    .fl_ce_n_o    (fl_ce_n_o),
    .fl_oe_n_o    (fl_oe_n_o),
    .fl_we_n_o    (fl_we_n_o),
    .fl_addr_o    (fl_addr_o),
    .fl_dq_o      (fl_dq_o),
    .fl_dq_oe_n_o (fl_dq_oe_n_o),
    .fl_dq_i      (fl_dq_i)
  );

  fwsr_irq u_irq (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ev_i    (ev),
    .clr_i   ((byte0_wr && adr_i == fwsr_pkg::REG_IRQ_CLR) ? dat_i[fwsr_pkg::NEV-1:0] : 3'h0),
    .en_we_i (byte0_wr && adr_i == fwsr_pkg::REG_IRQ_EN),
    .en_i    (dat_i[fwsr_pkg::NEV-1:0]),
    .stat_o  (irq_stat),
    .en_o    (irq_en),
    .irq_o   (irq_o)
  );
endmodule
`default_nettype wire

// ### verification/fwsr_properties.sv
// Bus and flash strobe checker for the flash status controller
`default_nettype none
module fwsr_properties (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    we_i,
  input wire logic [7:0]              adr_i,
  input wire logic [31:0]             dat_o,
  input wire logic                    ack_o,
  input wire logic                    irq_o,
  input wire logic                    fl_ce_n_o,
  input wire logic                    fl_oe_n_o,
  input wire logic                    fl_we_n_o,
  input wire logic [fwsr_pkg::AW-1:0] fl_addr_o,
  input wire logic                    fl_dq_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  unmapped_zero_a: assert property (ack_o && !$past(we_i) && $past(adr_i) >= 8'h20 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  rd_pulse_a: assert property ($fell(fl_oe_n_o) |-> !fl_oe_n_o [*3] ##1 fl_oe_n_o)
    else $error("read strobe width wrong");
  wr_pulse_a: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*2] ##1 fl_we_n_o)
    else $error("write strobe width wrong");
  strobe_excl_a: assert property (!fl_oe_n_o |-> fl_we_n_o && fl_dq_oe_n_o && !fl_ce_n_o)
    else $error("read strobe with write or drive");
  write_drive_a: assert property (!fl_we_n_o |-> !fl_dq_oe_n_o && !fl_ce_n_o)
    else $error("write strobe without data drive");
  addr_stable_a: assert property (!fl_ce_n_o && $past(!fl_ce_n_o) |-> $stable(fl_addr_o))
    else $error("flash address moved in a cycle");

  cover property ($fell(fl_we_n_o));
  cover property ($rose(irq_o));
  cover property (ack_o && !$past(we_i));
endmodule

bind fwsr_host fwsr_properties chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .fl_addr_o(fl_addr_o), .fl_dq_oe_n_o(fl_dq_oe_n_o));
`default_nettype wire

// ### verification/fwsr_flash_model.sv
// Behavioural flash device answering status reads and commands
`default_nettype none
module fwsr_flash_model (
  input  wire logic                    ce_n_i,
  input  wire logic                    oe_n_i,
  input  wire logic                    we_n_i,
  input  wire logic [fwsr_pkg::AW-1:0] addr_i,
  input  wire logic [fwsr_pkg::DW-1:0] dq_i,
  input  wire logic                    dq_oe_n_i,
  output logic      [fwsr_pkg::DW-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         busy    = 0;
  logic       fail    = 1'b0;
  logic       timer   = 1'b0;
  logic       expire  = 1'b0;
  logic       erase   = 1'b0;
  int         n_conf  = 0;
  int         n_reset = 0;
  logic       tog     = 1'b0;
  logic       drv     = 1'b0;
  logic [7:0] last    = 8'h00;
  logic       susp    = 1'b0;
  logic       wsel    = 1'b0;

  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      if (busy > 0 && susp) begin
        // Suspended sector gives steady status, other sectors array data
        last = (addr_i[16:14] == 3'h1) ? {1'b1, tog, 6'h00} : addr_i[7:0] ^ 8'h5A;
      end else if (busy > 0) begin
        last = {~erase, tog, fail, 1'b0, timer, 3'b000};
        tog = ~tog;
        busy--;
      end else begin
        last = addr_i[7:0] ^ 8'h5A;
      end
      drv = 1'b1;
    end
  end

  always @(posedge oe_n_i) drv = 1'b0;

  // Released bus shows the inverse of the last byte, never a held value
  assign dq_o = drv ? last : ~last;

  // Chip enable rises with the write strobe, so qualify the write at its falling edge
  always @(negedge we_n_i) wsel = !ce_n_i && !dq_oe_n_i;

  always @(posedge we_n_i) begin
    if (wsel) begin
      if (dq_i == 8'hF0) begin
        busy = 0;
        fail = 1'b0;
        n_reset++;
      end else if (dq_i == 8'h30 && busy > 0 && !timer) begin
        n_conf++;
        timer = expire;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/test_flash_write_status_reporting.sv
// Self-checking bench for the flash status controller
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module test_flash_write_status_reporting;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic        ack_o, irq_o, ce_n, oe_n, we_n, dq_oe_n;
  logic [16:0] fa;
  logic [7:0]  fdo, fdi;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          n0;

  always #12.5 clk_i = ~clk_i;

  fwsr_host uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .fl_ce_n_o(ce_n),
    .fl_oe_n_o(oe_n), .fl_we_n_o(we_n), .fl_addr_o(fa), .fl_dq_o(fdo), .fl_dq_oe_n_o(dq_oe_n), .fl_dq_i(fdi));
  fwsr_flash_model fm (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(fdo),
    .dq_oe_n_i(dq_oe_n), .dq_o(fdi));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 20) begin
      n_mismatch++;
      complete_run;
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 400; k++) begin
      wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0);
      if (rd[fwsr_pkg::ST_BUSY] === 1'b0) break;
    end
    if (k == 400) begin
      n_mismatch++;
      complete_run;
    end
  endtask

  task automatic run_op(input logic [2:0] op, input logic [16:0] a);
    wb(1'b1, fwsr_pkg::REG_ADDR, {15'h0, a});
    wb(1'b1, fwsr_pkg::REG_CMD, {29'h0, op});
    wait_idle;
  endtask

  task automatic st_chk(input int bitn);
    wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0);
    `CHK("status", 32'h1 << bitn, rd)
  endtask

  task automatic irq_chk(input logic [2:0] ev, input logic lvl);
    wb(1'b0, fwsr_pkg::REG_IRQ_STAT, 32'h0);
    `CHK("irq status", {29'h0, ev}, rd)
    `CHK("irq level", lvl, irq_o)
    wb(1'b1, fwsr_pkg::REG_IRQ_CLR, 32'h7);
    `CHK("irq cleared", 1'b0, irq_o)
  endtask

  task automatic t_regs;
    `CHK("irq idle", 1'b0, irq_o)
    wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0);
    `CHK("status reset", 32'h0, rd)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, fwsr_pkg::REG_ADDR, 32'hFFFF_FFFF);
    wb(1'b0, fwsr_pkg::REG_ADDR, 32'h0);
    `CHK("addr width", 32'h0001_FFFF, rd)
    wb(1'b1, fwsr_pkg::REG_IRQ_EN, 32'h7);
    wb(1'b0, fwsr_pkg::REG_IRQ_EN, 32'h0);
    `CHK("irq enable", 32'h7, rd)
    run_op(fwsr_pkg::OP_READ, 17'h00042);
    wb(1'b0, fwsr_pkg::REG_RDATA, 32'h0);
    `CHK("idle read", {24'h0, 8'h42 ^ 8'h5A}, rd)
    irq_chk(3'h1, 1'b1);
    $display("test registers done");
  endtask

  task automatic t_poll_ok;
    fm.busy = 5;
    run_op(fwsr_pkg::OP_POLL, 17'h00123);
    st_chk(fwsr_pkg::ST_OK);
    wb(1'b0, fwsr_pkg::REG_RDATA, 32'h0);
    `CHK("array after poll", {24'h0, 8'h23 ^ 8'h5A}, rd)
    irq_chk(3'h1, 1'b1);
    $display("test poll done");
  endtask

  task automatic t_poll_fail;
    n0 = fm.n_reset;
    fm.busy = 1000;
    fm.fail = 1'b1;
    run_op(fwsr_pkg::OP_POLL, 17'h00200);
    st_chk(fwsr_pkg::ST_FAIL);
    `CHK("reset command", 1, fm.n_reset - n0)
    irq_chk(3'h2, 1'b1);
    fm.busy = 2;
    fm.fail = 1'b1;
    run_op(fwsr_pkg::OP_POLL, 17'h00300);
    st_chk(fwsr_pkg::ST_OK);
    `CHK("no reset on late stop", 1, fm.n_reset - n0)
    fm.fail = 1'b0;
    irq_chk(3'h1, 1'b1);
    $display("test poll fail done");
  endtask

  task automatic t_abort;
    fm.busy = 1000;
    wb(1'b1, fwsr_pkg::REG_CMD, {29'h0, fwsr_pkg::OP_POLL});
    wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0);
    `CHK("poll running", 32'h1, rd)
    wb(1'b1, fwsr_pkg::REG_CMD, 32'h1 << fwsr_pkg::CMD_ABORT);
    wait_idle;
    st_chk(fwsr_pkg::ST_ABORTED);
    fm.busy = 3;
    run_op(fwsr_pkg::OP_POLL, 17'h00055);
    st_chk(fwsr_pkg::ST_OK);
    irq_chk(3'h1, 1'b1);
    $display("test abort done");
  endtask

  task automatic t_suspend;
    fm.busy = 5;
    fm.susp = 1'b1;
    run_op(fwsr_pkg::OP_POLL, 17'h04010);
    st_chk(fwsr_pkg::ST_OK);
    wb(1'b0, fwsr_pkg::REG_RDATA, 32'h0);
    `CHK("suspended status", 8'h80, rd[7:0] & 8'hBF)
    run_op(fwsr_pkg::OP_READ, 17'h00077);
    wb(1'b0, fwsr_pkg::REG_RDATA, 32'h0);
    `CHK("other sector data", {24'h0, 8'h77 ^ 8'h5A}, rd)
    fm.susp = 1'b0;
    fm.busy = 0;
    irq_chk(3'h1, 1'b1);
    $display("test suspend done");
  endtask

  task automatic t_erase;
    n0 = fm.n_conf;
    fm.busy = 1000;
    fm.erase = 1'b1;
    run_op(fwsr_pkg::OP_ERASE_ADD, 17'h04000);
    st_chk(fwsr_pkg::ST_OK);
    `CHK("sector accepted", 1, fm.n_conf - n0)
    irq_chk(3'h1, 1'b1);
    wb(1'b1, fwsr_pkg::REG_IRQ_EN, 32'h1);
    fm.timer = 1'b1;
    run_op(fwsr_pkg::OP_ERASE_ADD, 17'h08000);
    st_chk(fwsr_pkg::ST_DROPPED);
    `CHK("sector refused", 1, fm.n_conf - n0)
    irq_chk(3'h4, 1'b0);
    wb(1'b1, fwsr_pkg::REG_IRQ_EN, 32'h7);
    fm.timer = 1'b0;
    fm.expire = 1'b1;
    run_op(fwsr_pkg::OP_ERASE_ADD, 17'h0C000);
    st_chk(fwsr_pkg::ST_DROPPED);
    irq_chk(3'h4, 1'b1);
    run_op(fwsr_pkg::OP_RESET, 17'h00000);
    st_chk(fwsr_pkg::ST_OK);
    `CHK("device idle", 0, fm.busy)
    fm.timer = 1'b0;
    fm.erase = 1'b0;
    irq_chk(3'h1, 1'b1);
    $display("test erase done");
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_poll_ok;
    t_poll_fail;
    t_abort;
    t_suspend;
    t_erase;
    complete_run;
  end
endmodule
`default_nettype wire
